// >>> escs_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants for the external sample clock select block
// ---------------------------------------------------------------------------
package escs_pkg;

	// -----------------------------------------------------------------------
	// Bus geometry
	// -----------------------------------------------------------------------
	localparam int ESCS_ADR_W = 17;            // Byte address width on the bus
	localparam int ESCS_IDX_W = 15;            // Word index width (address / 4)
	localparam int ESCS_DAT_W = 32;            // Bus data width

	// -----------------------------------------------------------------------
	// Register word indices (byte address is four times the index)
	// -----------------------------------------------------------------------
	localparam logic [ESCS_IDX_W-1:0] ESCS_IDX_DIVISOR = 15'h4E48; // external_clock_divisor
	localparam logic [ESCS_IDX_W-1:0] ESCS_IDX_SOURCE  = 15'h4E84; // clock_source_select
	localparam logic [ESCS_IDX_W-1:0] ESCS_IDX_TERM    = 15'h4E98; // clock_input_termination
	localparam logic [ESCS_IDX_W-1:0] ESCS_IDX_BAND    = 15'h4EA2; // external_clock_band
	localparam logic [ESCS_IDX_W-1:0] ESCS_IDX_STATUS  = 15'h4F00; // clock_status

	// -----------------------------------------------------------------------
	// Field widths and reset values
	// -----------------------------------------------------------------------
	localparam int                   ESCS_DIV_W     = 11;            // Holds up to 2000
	localparam int                   ESCS_BAND_W    = 6;             // One-hot band, bits 5..1
	localparam logic [ESCS_DIV_W-1:0]  ESCS_DIV_RST  = 11'h001;      // Divide by one
	localparam logic [ESCS_BAND_W-1:0] ESCS_BAND_RST = 6'h02;        // Lowest band

	// Band codes
	localparam logic [ESCS_DAT_W-1:0] ESCS_BAND_LOWEST      = 32'h0000_0002;
	localparam logic [ESCS_DAT_W-1:0] ESCS_BAND_SMALL       = 32'h0000_0004;
	localparam logic [ESCS_DAT_W-1:0] ESCS_BAND_MEDIUM      = 32'h0000_0008;
	localparam logic [ESCS_DAT_W-1:0] ESCS_BAND_LARGE       = 32'h0000_0010;
	localparam logic [ESCS_DAT_W-1:0] band_extra_large      = 32'h0000_0020;
	localparam logic [ESCS_DAT_W-1:0] ESCS_BAND_MASK        = 32'h0000_003E;

	// Status bit positions
	localparam int ESCS_ST_PRESENT  = 0;       // External clock edges seen lately
	localparam int ESCS_ST_DIV_REJ  = 1;       // Sticky: divisor write refused
	localparam int ESCS_ST_BAND_REJ = 2;       // Sticky: band write refused

	// -----------------------------------------------------------------------
	// Accepted divisors
	// -----------------------------------------------------------------------
	localparam int ESCS_DIV_COUNT = 17;
	localparam logic [ESCS_DAT_W-1:0] ESCS_DIV_TABLE [0:ESCS_DIV_COUNT-1] = '{
		32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008,
		32'h0000_000A, 32'h0000_0010, 32'h0000_0014, 32'h0000_0028,
		32'h0000_0032, 32'h0000_0050, 32'h0000_0064, 32'h0000_00C8,
		32'h0000_0190, 32'h0000_01F4, 32'h0000_0320, 32'h0000_03E8,
		32'h0000_07D0
	};

	// -----------------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------------
	localparam int ESCS_CLK_PERIOD_NS = 8;     // 125 MHz system clock
	localparam int ESCS_IDLE_NS       = 4000;  // Edge gap that counts as clock lost
	localparam int ESCS_IDLE_CYC      = ESCS_IDLE_NS / ESCS_CLK_PERIOD_NS;
	localparam int ESCS_IDLE_W        = 10;    // Counter width for the idle count

endpackage

// >>> escs_divider.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Edge divider: one tick every divisor_i external clock edges
// ---------------------------------------------------------------------------
module escs_divider #(
	parameter int CNT_W = 11
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Control
	input  wire logic             edge_i,     // One pulse per external rising edge
	input  wire logic [CNT_W-1:0] divisor_i,  // Accepted divisor, never zero
	input  wire logic             restart_i,  // Realign count after a new divisor
	// Result
	output logic                  tick_o      // One-cycle divided sample tick
);

	logic [CNT_W-1:0] count_reg;   // Edges counted in the current period
	logic [CNT_W-1:0] count_next;
	logic             tick_reg;    // Registered tick
	logic             tick_next;
	logic [CNT_W-1:0] last_cnt;    // Terminal count of the period

	// Next count and tick; a divisor of one keeps the count at zero
	always_comb begin
		last_cnt   = divisor_i - CNT_W'(1);
		count_next = count_reg;
		tick_next  = 1'b0;
		if (restart_i) begin
			// Restart drops the partial period so the new ratio starts clean
			count_next = '0;
		end else if (edge_i) begin
			if (count_reg >= last_cnt) begin
				count_next = '0;
				tick_next  = 1'b1;
			end else begin
				count_next = count_reg + CNT_W'(1);
			end
		end
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= '0;
			tick_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign tick_o = tick_reg;

endmodule

// >>> escs_top.sv
`timescale 1ns/100ps
// How it works
// - source select 1 uses external clock, 0 internal
// - termination on only while connector is input
// - band takes one-hot 2..32; software picks band
// - divide external clock by accepted listed divisors
module escs_top
	import escs_pkg::*;
#(
	parameter int IDLE_CYC = ESCS_IDLE_CYC
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Wishbone classic slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [ESCS_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [ESCS_DAT_W-1:0] wb_dat_i,
	output logic      [ESCS_DAT_W-1:0] wb_dat_o,
	output logic                       wb_ack_o,
	// Clock sources
	input  wire logic                  ext_clk_i,        // Connector pin, asynchronous
	input  wire logic                  int_tick_i,       // Internal rate tick, same domain
	input  wire logic                  conn_drive_i,     // Connector driven as clock output
	// Conditioned outputs
	output logic                       sample_tick_o,    // Selected sample clock tick
	output logic                       ext_select_o,     // External source in use
	output logic                       term_en_o,        // 50 Ohm load switch
	output logic      [ESCS_BAND_W-1:0] band_o           // Band code to the front end
);

	// -----------------------------------------------------------------------
	// Pin synchroniser and edge detect
	// -----------------------------------------------------------------------
	logic ext_meta_reg;   // First stage, read by the second stage only
	logic ext_sync_reg;   // Second stage
	logic ext_prev_reg;   // Delayed copy for edge detect
	logic ext_edge;       // One pulse per rising edge of the pin

	// Two flip-flops before any logic sees the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			ext_meta_reg <= ext_clk_i;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
		end
	end

	// Rising edge; pins above half the system clock rate alias here
	assign ext_edge = ext_sync_reg & ~ext_prev_reg;

	// -----------------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------------
	logic [ESCS_IDX_W-1:0] idx;       // Word index of the access
	logic                  req;       // Request pending, not yet answered
	logic                  wr_take;   // Write commits on this edge
	logic [ESCS_DAT_W-1:0] bmask;     // Byte enables widened to bits

	assign idx     = wb_adr_i[ESCS_ADR_W-1:2];
	assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge where the master sees ack
	assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	// Byte lane mask, one generate step per lane
	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_lane
			assign bmask[gl*8 +: 8] = {8{wb_sel_i[gl]}};
		end
	endgenerate

	// -----------------------------------------------------------------------
	// Value checks
	// -----------------------------------------------------------------------

	// True for a divisor found in the accepted list
	function automatic logic div_ok(input logic [ESCS_DAT_W-1:0] v);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < ESCS_DIV_COUNT; i++) begin
			if (v == ESCS_DIV_TABLE[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// True for one of the five one-hot band codes
	function automatic logic band_ok(input logic [ESCS_DAT_W-1:0] v);
		return ((v & ~ESCS_BAND_MASK) == '0) && $onehot(v);
	endfunction

	// -----------------------------------------------------------------------
	// Configuration and status registers
	// -----------------------------------------------------------------------
	logic [ESCS_DIV_W-1:0]  div_reg;        // Accepted divisor
	logic [ESCS_DIV_W-1:0]  div_next;
	logic                   src_reg;        // 1 selects the external source
	logic                   src_next;
	logic                   term_reg;       // Termination requested by software
	logic                   term_next;
	logic [ESCS_BAND_W-1:0] band_reg;       // Programmed band
	logic [ESCS_BAND_W-1:0] band_next;
	logic                   div_rej_reg;    // Sticky refused divisor write
	logic                   div_rej_next;
	logic                   band_rej_reg;   // Sticky refused band write
	logic                   band_rej_next;
	logic                   restart;        // Divider realign pulse
	logic [ESCS_DAT_W-1:0]  div_old;        // Stored divisor at bus width
	logic [ESCS_DAT_W-1:0]  band_old;       // Stored band at bus width
	logic [ESCS_DAT_W-1:0]  div_wr;         // Merged divisor write value
	logic [ESCS_DAT_W-1:0]  band_wr;        // Merged band write value
	logic                   div_set;        // Refused divisor event
	logic                   band_set;       // Refused band event
	logic                   st_clr_div;     // Software clears divisor flag
	logic                   st_clr_band;    // Software clears band flag

	assign div_old  = ESCS_DAT_W'(div_reg);
	assign band_old = ESCS_DAT_W'(band_reg);
	// Partial writes merge with the stored value before the check
	assign div_wr   = (wb_dat_i & bmask) | (div_old & ~bmask);
	assign band_wr  = (wb_dat_i & bmask) | (band_old & ~bmask);

	// Next register values from the committed write
	always_comb begin
		div_next      = div_reg;
		src_next      = src_reg;
		term_next     = term_reg;
		band_next     = band_reg;
		restart       = 1'b0;
		div_set       = 1'b0;
		band_set      = 1'b0;
		st_clr_div    = 1'b0;
		st_clr_band   = 1'b0;
		if (wr_take) begin
			case (idx)
				ESCS_IDX_DIVISOR: begin
					// A bad divisor keeps the old one rather than stall the clock
					if (div_ok(div_wr)) begin
						div_next = div_wr[ESCS_DIV_W-1:0];
						restart  = 1'b1;
					end else begin
						div_set = 1'b1;
					end
				end
				ESCS_IDX_SOURCE: begin
					if (wb_sel_i[0]) begin
						src_next = wb_dat_i[0];
					end
				end
				ESCS_IDX_TERM: begin
					if (wb_sel_i[0]) begin
						term_next = wb_dat_i[0];
					end
				end
				ESCS_IDX_BAND: begin
					// Only the five listed codes reach the front end
					if (band_ok(band_wr)) begin
						band_next = band_wr[ESCS_BAND_W-1:0];
					end else begin
						band_set = 1'b1;
					end
				end
				ESCS_IDX_STATUS: begin
					// Write one to clear each sticky flag
					if (wb_sel_i[0]) begin
						st_clr_div  = wb_dat_i[ESCS_ST_DIV_REJ];
						st_clr_band = wb_dat_i[ESCS_ST_BAND_REJ];
					end
				end
				default: begin
					// Unmapped: write is answered and dropped
				end
			endcase
		end
		// A new event outweighs a clear in the same cycle
		div_rej_next  = div_set | (div_rej_reg & ~st_clr_div);
		band_rej_next = band_set | (band_rej_reg & ~st_clr_band);
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg      <= ESCS_DIV_RST;
			src_reg      <= 1'b0;
			term_reg     <= 1'b0;
			band_reg     <= ESCS_BAND_RST;
			div_rej_reg  <= 1'b0;
			band_rej_reg <= 1'b0;
		end else begin
			div_reg      <= div_next;
			src_reg      <= src_next;
			term_reg     <= term_next;
			band_reg     <= band_next;
			div_rej_reg  <= div_rej_next;
			band_rej_reg <= band_rej_next;
		end
	end

	// -----------------------------------------------------------------------
	// External clock presence
	// -----------------------------------------------------------------------
	logic [ESCS_IDLE_W-1:0] idle_reg;      // Cycles since the last edge
	logic [ESCS_IDLE_W-1:0] idle_next;
	logic                   present_reg;   // Edges arriving often enough
	logic                   present_next;

	// Saturating gap counter; a slow source that breaks the minimum rate drops out
	always_comb begin
		idle_next    = idle_reg;
		present_next = present_reg;
		if (ext_edge) begin
			idle_next    = '0;
			present_next = 1'b1;
		end else if (idle_reg >= ESCS_IDLE_W'(IDLE_CYC - 1)) begin
			present_next = 1'b0;
		end else begin
			idle_next = idle_reg + ESCS_IDLE_W'(1);
		end
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_reg    <= '0;
			present_reg <= 1'b0;
		end else begin
			idle_reg    <= idle_next;
			present_reg <= present_next;
		end
	end

	// -----------------------------------------------------------------------
	// Divider and source mux
	// -----------------------------------------------------------------------
	logic div_tick;          // Divided external tick
	logic sample_reg;        // Selected sample tick
	logic sample_next;
	logic term_out_reg;      // Load switch state
	logic term_out_next;

	// Divider runs whatever the source, so switching over finds it aligned
	escs_divider #(
		.CNT_W     (ESCS_DIV_W)
	) u_div (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.edge_i    (ext_edge),
		.divisor_i (div_reg),
		.restart_i (restart),
		.tick_o    (div_tick)
	);

	// Source mux and termination gate
	always_comb begin
		sample_next   = src_reg ? div_tick : int_tick_i;
		// Load only while the connector is not being driven
		term_out_next = term_reg & ~conn_drive_i;
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_reg   <= 1'b0;
			term_out_reg <= 1'b0;
		end else begin
			sample_reg   <= sample_next;
			term_out_reg <= term_out_next;
		end
	end

	// -----------------------------------------------------------------------
	// Bus answer
	// -----------------------------------------------------------------------
	logic                  ack_reg;    // Answer strobe
	logic                  ack_next;
	logic [ESCS_DAT_W-1:0] rdat_reg;   // Read data
	logic [ESCS_DAT_W-1:0] rdat_next;

	// One wait state; read data frozen with the ack
	always_comb begin
		ack_next  = req;
		rdat_next = '0;
		if (req) begin
			case (idx)
				ESCS_IDX_DIVISOR: rdat_next = div_old;
				ESCS_IDX_SOURCE:  rdat_next = ESCS_DAT_W'(src_reg);
				ESCS_IDX_TERM:    rdat_next = ESCS_DAT_W'(term_reg);
				ESCS_IDX_BAND:    rdat_next = band_old;
				ESCS_IDX_STATUS: begin
					rdat_next[ESCS_ST_PRESENT]  = present_reg;
					rdat_next[ESCS_ST_DIV_REJ]  = div_rej_reg;
					rdat_next[ESCS_ST_BAND_REJ] = band_rej_reg;
				end
				default:          rdat_next = '0;
			endcase
		end
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= '0;
		end else begin
			ack_reg  <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	// -----------------------------------------------------------------------
	// Outputs, each straight from a flip-flop
	// -----------------------------------------------------------------------
	assign wb_ack_o      = ack_reg;
	assign wb_dat_o      = rdat_reg;
	assign sample_tick_o = sample_reg;
	assign ext_select_o  = src_reg;
	assign term_en_o     = term_out_reg;
	assign band_o        = band_reg;

endmodule

// >>> escs_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the sample clock select
// ----------------------------------------
module escs_props
	import escs_pkg::*;
(
	// Clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	// Bus
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic [ESCS_DAT_W-1:0] wb_dat_o,
	input wire logic                  wb_ack_o,
	// Clocking
	input wire logic                  int_tick_i,
	input wire logic                  conn_drive_i,
	input wire logic                  sample_tick_o,
	input wire logic                  ext_select_o,
	input wire logic                  term_en_o,
	input wire logic [ESCS_BAND_W-1:0] band_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Fresh request, not yet answered
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Internal tick while the internal source has been steady
	sequence s_int;
		!ext_select_o [*2] ##0 int_tick_i ##1 !ext_select_o;
	endsequence

	chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("request not answered");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
	chk_int_pass: assert property (s_int |-> sample_tick_o) else $error("internal tick lost");
	chk_int_quiet: assert property (!ext_select_o [*2] ##0 !$past(int_tick_i) |-> !sample_tick_o)
		else $error("tick without internal cause");
	// Pin slower than clk/4 means divided ticks never come back to back
	chk_ext_gap: assert property (ext_select_o && sample_tick_o |=> !sample_tick_o)
		else $error("divided ticks adjacent");
	chk_term_off: assert property (conn_drive_i |=> !term_en_o) else $error("load on driven pin");
	chk_term_cause: assert property ($rose(term_en_o) |-> $past(!conn_drive_i))
		else $error("load switched on while driving");
	chk_band_code: assert property ($onehot(band_o) && !band_o[0]) else $error("band not one-hot");
endmodule

// >>> escs_ext_clk_gen.sv
`timescale 1ns/100ps
// ----------------------------------------
// External clock source on the connector
// ----------------------------------------
module escs_ext_clk_gen (
	// Control
	input  wire logic        run_i,     // Frame enable
	input  wire logic [31:0] half_ns_i, // Half period
	// Connector
	output logic             clk_o      // Sample clock pin
);
	// Stands low outside frames; a frame finishes its high phase first
	// Half periods of 40 to 1000 ns keep the rate in 0.5..12.5 MHz
	always begin
		if (run_i) begin
			clk_o = 1'b1;
			#(half_ns_i);
			clk_o = 1'b0;
			#(half_ns_i);
		end else begin
			// One driver only: the idle level is set here as well
			clk_o = 1'b0;
			@(run_i);
		end
	end
endmodule

// >>> escs_top_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module escs_top_tb;
	import escs_pkg::*;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [ESCS_ADR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = '0, wb_dat_o, q, m_div = 1, m_src = 0, m_term = 0, m_band = 2, m_st = 0;
	logic wb_ack_o, ext_clk_i, int_tick_i = 0, conn_drive_i = 0, run = 0, int_run = 0;
	logic sample_tick_o, ext_select_o, term_en_o;
	logic [ESCS_BAND_W-1:0] band_o;
	int n_fail = 0, checks_done = 0, n_tick, n_int, n_edge, half = 40, i, s;
	int dv[17] = '{1, 2, 4, 8, 10, 16, 20, 40, 50, 80, 100, 200, 400, 500, 800, 1000, 2000};

	escs_top #(.IDLE_CYC(20)) i_escs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
		.int_tick_i(int_tick_i), .conn_drive_i(conn_drive_i), .sample_tick_o(sample_tick_o),
		.ext_select_o(ext_select_o), .term_en_o(term_en_o), .band_o(band_o));
	escs_ext_clk_gen i_escs_ext_clk_gen (.run_i(run), .half_ns_i(half), .clk_o(ext_clk_i));

	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Tick tallies; pulses are sampled as the design sees them
	always @(posedge clk_i) begin
		if (sample_tick_o === 1'b1) n_tick++;
		if (int_tick_i === 1'b1) n_int++;
		int_tick_i <= int_run ? 1'($urandom_range(0, 1)) : 1'b0;
	end
	always @(posedge ext_clk_i) n_edge++;

	task automatic end_of_test;
		if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// One classic cycle; held until ack, then released
	task automatic wb(input logic [14:0] idx, input logic we, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, d};
		for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
		if (k == 20) begin
			chk(0, 1, "ack timeout");
			end_of_test();
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask
	// Write plus model update; refused values keep the old setting
	task automatic wr(input logic [14:0] idx, input logic [31:0] d);
		wb(idx, 1, d);
		case (idx)
			ESCS_IDX_DIVISOR: if (d inside {dv}) m_div = d; else m_st |= 2;
			ESCS_IDX_BAND: if (d inside {2, 4, 8, 16, 32}) m_band = d; else m_st |= 4;
			ESCS_IDX_SOURCE: m_src = d;
			ESCS_IDX_TERM: m_term = d;
			ESCS_IDX_STATUS: m_st &= ~d;
			default: ;
		endcase
	endtask
	// Read compared with the model; status presence bit left out
	task automatic rd(input logic [14:0] idx);
		wb(idx, 0, 0);
		case (idx)
			ESCS_IDX_DIVISOR: chk(q, m_div, "divisor");
			ESCS_IDX_BAND: chk(q, m_band, "band");
			ESCS_IDX_SOURCE: chk(q, m_src, "source");
			ESCS_IDX_TERM: chk(q, m_term, "termination");
			ESCS_IDX_STATUS: chk(q & 6, m_st, "status");
			default: chk(q, 0, "unmapped read");
		endcase
	endtask
	// Run a frame of e edges on the connector
	task automatic burst(input int e);
		int k;
		n_edge = 0;
		run <= 1;
		for (k = 0; k < 5000 && n_edge < e; k++) @(posedge clk_i);
		run <= 0;
		if (k == 5000) begin
			chk(0, 1, "edge timeout");
			end_of_test();
		end
	endtask

	initial begin
		s = $urandom(56216);
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		foreach (dv[j]) rd(j == 0 ? ESCS_IDX_DIVISOR : j == 1 ? ESCS_IDX_SOURCE : j == 2 ?
			ESCS_IDX_TERM : ESCS_IDX_BAND);
		chk(band_o, 2, "band pin at reset");
		// Every accepted divisor, then refused ones
		foreach (dv[j]) begin
			wr(ESCS_IDX_DIVISOR, dv[j]);
			rd(ESCS_IDX_DIVISOR);
		end
		wr(ESCS_IDX_DIVISOR, 3);
		wr(ESCS_IDX_DIVISOR, $urandom_range(0, 2047));
		rd(ESCS_IDX_DIVISOR);
		rd(ESCS_IDX_STATUS);
		// Every band code and some illegal ones
		for (i = 1; i < 6; i++) begin
			wr(ESCS_IDX_BAND, 1 << i);
			rd(ESCS_IDX_BAND);
			chk(band_o, 1 << i, "band pin");
		end
		wr(ESCS_IDX_BAND, 6);
		wr(ESCS_IDX_BAND, 1);
		wr(ESCS_IDX_BAND, 64);
		rd(ESCS_IDX_BAND);
		rd(ESCS_IDX_STATUS);
		wr(ESCS_IDX_STATUS, 6);
		rd(ESCS_IDX_STATUS);
		wr(15'h0100, 32'h0000_00FF);
		rd(15'h0100);
		// Load only while the pin is an input
		wr(ESCS_IDX_TERM, 1);
		rd(ESCS_IDX_TERM);
		repeat (3) @(posedge clk_i);
		chk(term_en_o, 1, "load off on input");
		conn_drive_i <= 1;
		repeat (3) @(posedge clk_i);
		chk(term_en_o, 0, "load on while driving");
		conn_drive_i <= 0;
		// Internal source follows the internal tick
		int_run <= 1;
		n_tick = 0;
		n_int = 0;
		repeat (60) @(posedge clk_i);
		int_run <= 0;
		repeat (4) @(posedge clk_i);
		chk(n_tick, n_int, "internal tick count");
		// External source, internal ticks kept running to show they are ignored
		wr(ESCS_IDX_SOURCE, 1);
		repeat (3) @(posedge clk_i);
		chk(ext_select_o, 1, "external select pin");
		int_run <= 1;
		for (i = 0; i < 4; i++) begin
			wr(ESCS_IDX_DIVISOR, dv[i * 2]);
			half = i == 3 ? 120 : 40;
			n_tick = 0;
			burst(20);
			// Edges ten cycles apart keep the presence flag up
			if (i == 0) begin
				rd(ESCS_IDX_STATUS);
				chk(q & 1, 1, "clock not present");
			end
			repeat (10) @(posedge clk_i);
			chk(n_tick, 20 / dv[i * 2], "divided tick count");
		end
		// Pin quiet for longer than the idle limit: presence must drop
		repeat (30) @(posedge clk_i);
		rd(ESCS_IDX_STATUS);
		chk(q & 1, 0, "clock still present");
		end_of_test();
	end
endmodule

bind escs_top escs_props i_escs_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_tick_i(int_tick_i),
	.conn_drive_i(conn_drive_i), .sample_tick_o(sample_tick_o), .ext_select_o(ext_select_o),
	.term_en_o(term_en_o), .band_o(band_o));
